// ===== verilog/bus_transceiver.sv
// Summary of operation
// - every path copies its source level to the driven port without inversion
// - one eight-bit storing transceiver plus two single-bit transceivers with monitors
// - a single-bit backplane pin is driven exactly while its drive enable is high
// - a monitor output is driven while its low-active enable is low
// - both enables on: drive local bit out and copy backplane bit back
// - octal enable high floats all sixteen octal port outputs
// - octal enable low: direction high drives backplane side, low card side
// - transparency gate high: stored value follows the source continuously
// - gate low, direction clock steady: stored value holds, source ignored
// - gate low: rising direction clock captures the source
// - gate falling keeps the level present just before the fall
// - inbound direction behaves the same, timed by the inbound clock
module bus_transceiver (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [xcvr_pkg::OCTAL_W-1:0] octal_card_port_in,
  output logic [xcvr_pkg::OCTAL_W-1:0] octal_card_port_out,
  output logic [xcvr_pkg::OCTAL_W-1:0] octal_card_port_oe,
  input wire logic [xcvr_pkg::OCTAL_W-1:0] octal_backplane_port_in,
  output logic [xcvr_pkg::OCTAL_W-1:0] octal_backplane_port_out,
  output logic [xcvr_pkg::OCTAL_W-1:0] octal_backplane_port_oe,
  input wire logic output_enable_n,
  input wire logic direction_select,
  input wire logic transparency_gate,
  input wire logic outbound_clock,
  input wire logic inbound_clock,
  input wire logic bit_one_local_in,
  input wire logic bit_two_local_in,
  input wire logic [xcvr_pkg::BIT_CHANNELS-1:0] backplane_drive_enable,
  input wire logic [xcvr_pkg::BIT_CHANNELS-1:0] monitor_enable_n,
  input wire logic bit_one_backplane_io_in,
  output logic bit_one_backplane_io_out,
  output logic bit_one_backplane_io_oe,
  input wire logic bit_two_backplane_io_in,
  output logic bit_two_backplane_io_out,
  output logic bit_two_backplane_io_oe,
  output logic bit_one_monitor_out,
  output logic bit_one_monitor_oe,
  output logic bit_two_monitor_out,
  output logic bit_two_monitor_oe,
  output logic [xcvr_pkg::OCTAL_W-1:0] capture_word,
  output logic capture_valid,
  input wire logic capture_ready,
  output logic capture_room
);
  import xcvr_pkg::*;

  logic [SYNC_W-1:0] pins_raw, pins_s;
  logic [OCTAL_W-1:0] card_s, back_s;
  logic [BIT_CHANNELS-1:0] local_s, bpbit_s, drive_s, mon_n_s;
  logic oe_n_s, dir_s, gate_s;
  logic [DIRECTIONS-1:0] dclk_s;

  // every pin is asynchronous to core_clk, so all of them share one synchroniser
  assign pins_raw = {inbound_clock, outbound_clock, transparency_gate,
                     direction_select, output_enable_n, monitor_enable_n,
                     backplane_drive_enable,
                     bit_two_backplane_io_in, bit_one_backplane_io_in,
                     bit_two_local_in, bit_one_local_in,
                     octal_backplane_port_in, octal_card_port_in};

  pin_sync #(.W(SYNC_W), .RST(SYNC_RST)) u_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pin_in(pins_raw),
    .level_out(pins_s)
  );

  // unpack the filtered levels
  assign card_s = pins_s[POS_CARD +: OCTAL_W];
  assign back_s = pins_s[POS_BACK +: OCTAL_W];
  assign local_s = pins_s[POS_LOCAL +: BIT_CHANNELS];
  assign bpbit_s = pins_s[POS_BPBIT +: BIT_CHANNELS];
  assign drive_s = pins_s[POS_DRIVE +: BIT_CHANNELS];
  assign mon_n_s = pins_s[POS_MON +: BIT_CHANNELS];
  assign oe_n_s = pins_s[POS_OE];
  assign dir_s = pins_s[POS_DIR];
  assign gate_s = pins_s[POS_GATE];
  assign dclk_s[DIR_OUT] = pins_s[POS_CLK_OUT];
  assign dclk_s[DIR_IN] = pins_s[POS_CLK_IN];

  // per-direction storage element: latch and edge flop merged into one register
  logic [OCTAL_W-1:0] store_r [DIRECTIONS];
  logic [OCTAL_W-1:0] store_nxt [DIRECTIONS];
  logic [OCTAL_W-1:0] src [DIRECTIONS];
  logic [DIRECTIONS-1:0] clk_prev_r, clk_prev_nxt, rise;

  assign src[DIR_OUT] = card_s;
  assign src[DIR_IN] = back_s;

  genvar d;
  generate
    for (d = 0; d < DIRECTIONS; d++) begin : g_dir
      // gate high tracks the source, so at the gate's fall the register already
      // holds the level present just before it; enables play no part here
      always_comb begin
        rise[d] = dclk_s[d] && !clk_prev_r[d];
        clk_prev_nxt[d] = dclk_s[d];
        if (gate_s) begin
          store_nxt[d] = src[d];
        end else if (rise[d]) begin
          store_nxt[d] = src[d];
        end else begin
          store_nxt[d] = store_r[d];
        end
      end

      always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
          store_r[d] <= STORE_RST;
          clk_prev_r[d] <= 1'b0;
        end else begin
          store_r[d] <= store_nxt[d];
          clk_prev_r[d] <= clk_prev_nxt[d];
        end
      end
    end
  endgenerate

  // octal drivers: enable decides whether, direction decides which side
  logic [OCTAL_W-1:0] bp_out_r, bp_out_nxt, bp_oe_r, bp_oe_nxt;
  logic [OCTAL_W-1:0] cd_out_r, cd_out_nxt, cd_oe_r, cd_oe_nxt;

  always_comb begin
    bp_out_nxt = store_nxt[DIR_OUT];
    cd_out_nxt = store_nxt[DIR_IN];
    bp_oe_nxt = {OCTAL_W{!oe_n_s && dir_s}};
    cd_oe_nxt = {OCTAL_W{!oe_n_s && !dir_s}};
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bp_out_r <= STORE_RST;
      cd_out_r <= STORE_RST;
      bp_oe_r <= '0;
      cd_oe_r <= '0;
    end else begin
      bp_out_r <= bp_out_nxt;
      cd_out_r <= cd_out_nxt;
      bp_oe_r <= bp_oe_nxt;
      cd_oe_r <= cd_oe_nxt;
    end
  end

  assign octal_backplane_port_out = bp_out_r;
  assign octal_backplane_port_oe = bp_oe_r;
  assign octal_card_port_out = cd_out_r;
  assign octal_card_port_oe = cd_oe_r;

  // single-bit channels: the two enables act independently, so both may be on
  logic [BIT_CHANNELS-1:0] bo_r, bo_nxt, bo_oe_r, bo_oe_nxt;
  logic [BIT_CHANNELS-1:0] mo_r, mo_nxt, mo_oe_r, mo_oe_nxt;

  genvar b;
  generate
    for (b = 0; b < BIT_CHANNELS; b++) begin : g_bit
      always_comb begin
        bo_nxt[b] = local_s[b];
        bo_oe_nxt[b] = drive_s[b];
        mo_nxt[b] = bpbit_s[b];
        mo_oe_nxt[b] = !mon_n_s[b];
      end

      always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
          bo_r[b] <= 1'b0;
          bo_oe_r[b] <= 1'b0;
          mo_r[b] <= 1'b0;
          mo_oe_r[b] <= 1'b0;
        end else begin
          bo_r[b] <= bo_nxt[b];
          bo_oe_r[b] <= bo_oe_nxt[b];
          mo_r[b] <= mo_nxt[b];
          mo_oe_r[b] <= mo_oe_nxt[b];
        end
      end
    end
  endgenerate

  // two single-bit channels beside the octal path
  assign bit_one_backplane_io_out = bo_r[0];
  assign bit_one_backplane_io_oe = bo_oe_r[0];
  assign bit_two_backplane_io_out = bo_r[1];
  assign bit_two_backplane_io_oe = bo_oe_r[1];
  assign bit_one_monitor_out = mo_r[0];
  assign bit_one_monitor_oe = mo_oe_r[0];
  assign bit_two_monitor_out = mo_r[1];
  assign bit_two_monitor_oe = mo_oe_r[1];

  // clocked outbound captures also go to card logic as a word stream;
  // a full buffer shows as capture_room low and later captures are not queued
  logic cap_push;
  assign cap_push = !gate_s && rise[DIR_OUT];

  word_buffer #(.W(OCTAL_W)) u_capture (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .in_valid(cap_push),
    .in_ready(capture_room),
    .in_data(card_s),
    .out_valid(capture_valid),
    .out_ready(capture_ready),
    .out_data(capture_word)
  );

  // checks on the storage and driver behaviour
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  sequence gate_fell_clk_high;
    $fell(gate_s) && dclk_s[DIR_OUT] && !rise[DIR_OUT];
  endsequence

  sequence held_steady;
    !gate_s && !rise[DIR_OUT];
  endsequence

  a_octal_isolate: assert property (
    oe_n_s |=> bp_oe_r == '0 && cd_oe_r == '0)
    else $error("octal port driven while disabled");

  a_dir_choice: assert property (
    !oe_n_s |=> (bp_oe_r == {OCTAL_W{$past(dir_s)}}) &&
                (cd_oe_r == {OCTAL_W{!$past(dir_s)}}))
    else $error("octal side does not match direction");

  // the driver register loads from store_nxt, so it moves on the same edge as the store
  a_transparent_follow: assert property (
    gate_s |=> store_r[DIR_OUT] == $past(card_s) &&
               bp_out_r == $past(card_s))
    else $error("transparent path does not follow source");

  a_latched_hold: assert property (
    !gate_s && !rise[DIR_OUT] |=> store_r[DIR_OUT] == $past(store_r[DIR_OUT]))
    else $error("latched value changed without clock edge");

  a_edge_capture: assert property (
    !gate_s && rise[DIR_OUT] |=> store_r[DIR_OUT] == $past(card_s))
    else $error("rising clock did not capture source");

  // the kept level is the source seen in the last transparent cycle
  a_gate_fall_hold: assert property (
    gate_fell_clk_high ##1 held_steady |->
      store_r[DIR_OUT] == $past(card_s, 2))
    else $error("level before gate fall not kept");

  a_inbound_capture: assert property (
    !gate_s && rise[DIR_IN] |=> store_r[DIR_IN] == $past(back_s) &&
                                cd_out_r == $past(back_s))
    else $error("inbound clock did not capture backplane word");

  a_store_while_off: assert property (
    oe_n_s && gate_s |=> store_r[DIR_IN] == $past(back_s))
    else $error("storage frozen while outputs disabled");

  a_bit_drive: assert property (
    drive_s[0] |=> bo_oe_r[0] && bo_r[0] == $past(local_s[0]))
    else $error("backplane bit not driven with local level");

  a_bit_float: assert property (
    !drive_s[1] |=> !bo_oe_r[1])
    else $error("backplane bit driven while enable low");

  a_monitor_gate: assert property (
    mon_n_s[0] |=> !mo_oe_r[0])
    else $error("monitor driven while its enable is high");

  a_feedback_both: assert property (
    drive_s[1] && !mon_n_s[1] |=> bo_oe_r[1] && mo_oe_r[1] &&
      bo_r[1] == $past(local_s[1]) && mo_r[1] == $past(bpbit_s[1]))
    else $error("drive with feedback path broken");

endmodule : bus_transceiver

// ===== common/xcvr_pkg.sv
package xcvr_pkg;
  // octal path and single-bit channel geometry
  localparam int OCTAL_W = 8;
  localparam int BIT_CHANNELS = 2;
  localparam int DIRECTIONS = 2;
  localparam int DIR_OUT = 0;
  localparam int DIR_IN = 1;
  localparam int BUF_DEPTH = 2;
  localparam logic [OCTAL_W-1:0] STORE_RST = 8'h00;
  // bit positions of the packed pin vector fed through the synchroniser
  localparam int POS_CARD = 0;
  localparam int POS_BACK = 8;
  localparam int POS_LOCAL = 16;
  localparam int POS_BPBIT = 18;
  localparam int POS_DRIVE = 20;
  localparam int POS_MON = 22;
  localparam int POS_OE = 24;
  localparam int POS_DIR = 25;
  localparam int POS_GATE = 26;
  localparam int POS_CLK_OUT = 27;
  localparam int POS_CLK_IN = 28;
  localparam int SYNC_W = 29;
  // resting levels: every enable in its disabled state
  localparam logic [SYNC_W-1:0] SYNC_RST = 29'h1c00000;
endpackage : xcvr_pkg

// ===== verilog/pin_sync.sv
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level_out
);
  logic [W-1:0] meta_r, mid_r, late_r, level_r;
  logic [W-1:0] level_nxt;

  // a bit only moves once the second and third stage agree, filtering glitches
  always_comb begin
    for (int i = 0; i < W; i++) begin
      level_nxt[i] = (mid_r[i] == late_r[i]) ? late_r[i] : level_r[i];
    end
  end

  // first stage feeds only the second
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_r <= RST;
      mid_r <= RST;
      late_r <= RST;
      level_r <= RST;
    end else begin
      meta_r <= pin_in;
      mid_r <= meta_r;
      late_r <= mid_r;
      level_r <= level_nxt;
    end
  end

  assign level_out = level_r;
endmodule : pin_sync

// ===== verilog/word_buffer.sv
module word_buffer #(
  parameter int W = 8
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  import xcvr_pkg::*;

  logic [W-1:0] head_r, head_nxt, tail_r, tail_nxt;
  logic [1:0] count_r, count_nxt;
  logic valid_r, valid_nxt, room_r, room_nxt;
  logic push, pop;

  // head is presented straight from a flop; tail only holds the second word
  always_comb begin
    push = in_valid && room_r;
    pop = valid_r && out_ready;
    head_nxt = head_r;
    tail_nxt = tail_r;
    count_nxt = count_r;
    case (count_r)
      2'h0: begin
        if (push) begin
          head_nxt = in_data;
          count_nxt = 2'h1;
        end
      end
      2'h1: begin
        if (push && pop) begin
          head_nxt = in_data;
        end else if (push) begin
          tail_nxt = in_data;
          count_nxt = 2'h2;
        end else if (pop) begin
          count_nxt = 2'h0;
        end
      end
      2'h2: begin
        if (pop) begin
          head_nxt = tail_r;
          count_nxt = 2'h1;
        end
      end
      default: count_nxt = 2'h0;
    endcase
    valid_nxt = (count_nxt != 2'h0);
    room_nxt = (count_nxt != 2'(BUF_DEPTH));
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      head_r <= '0;
      tail_r <= '0;
      count_r <= 2'h0;
      valid_r <= 1'b0;
      room_r <= 1'b1;
    end else begin
      head_r <= head_nxt;
      tail_r <= tail_nxt;
      count_r <= count_nxt;
      valid_r <= valid_nxt;
      room_r <= room_nxt;
    end
  end

  assign in_ready = room_r;
  assign out_valid = valid_r;
  assign out_data = head_r;

  // a stalled head word must not change under the receiver
  a_head_stable: assert property (@(posedge core_clk) disable iff (sys_rst)
    valid_r && !out_ready |=> valid_r && head_r == $past(head_r))
    else $error("buffered word changed while stalled");
endmodule : word_buffer

// ===== test/backplane_model.sv
// far side of the backplane: octal lines and the two single-bit lines
module backplane_model (
  input wire logic core_clk,
  input wire logic drive_en,
  input wire logic [xcvr_pkg::OCTAL_W-1:0] drive_val,
  input wire logic [xcvr_pkg::OCTAL_W-1:0] octal_out,
  input wire logic [xcvr_pkg::OCTAL_W-1:0] octal_oe,
  input wire logic [1:0] bit_out,
  input wire logic [1:0] bit_oe,
  input wire logic [1:0] bit_val,
  output logic [xcvr_pkg::OCTAL_W-1:0] octal_wire,
  output logic [1:0] bit_wire
);
  timeunit 1ns;
  timeprecision 1ps;
  import xcvr_pkg::*;
  logic [OCTAL_W-1:0] last_r = 8'h00;
  // an undriven line toggles every cycle, so the synchroniser filter never passes it and the device keeps the last stable level
  always_ff @(posedge core_clk) last_r <= octal_wire;
  // device driver wins, then the remote card, else the floating pattern
  always_comb begin
    for (int i = 0; i < OCTAL_W; i++) begin
      if (octal_oe[i]) octal_wire[i] = octal_out[i];
      else if (drive_en) octal_wire[i] = drive_val[i];
      else octal_wire[i] = ~last_r[i];
    end
  end
  // single-bit lines are held by the remote driver whenever the device lets go
  assign bit_wire = (bit_oe & bit_out) | (~bit_oe & bit_val);
endmodule : backplane_model

// ===== test/bus_transceiver_tb.sv
module bus_transceiver_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import xcvr_pkg::*;
  logic core_clk, sys_rst, oe_n, dir, gate, clk_out, clk_in, bp_en;
  logic cap_valid, cap_ready, cap_room;
  logic [7:0] card_drv, card_in, card_out, card_oe, bp_in, bp_out, bp_oe, bp_val, cap_word;
  logic [1:0] loc, de, men, bit_in, bit_out, bit_oe, mon, mon_oe, bit_val;
  int n_mismatch = 0;
  int n_compared = 0;

  // card side: the device's own driver wins over the bench's card logic
  assign card_in = (card_oe & card_out) | (~card_oe & card_drv);

  bus_transceiver DUT (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .octal_card_port_in(card_in),
    .octal_card_port_out(card_out),
    .octal_card_port_oe(card_oe),
    .octal_backplane_port_in(bp_in),
    .octal_backplane_port_out(bp_out),
    .octal_backplane_port_oe(bp_oe),
    .output_enable_n(oe_n),
    .direction_select(dir),
    .transparency_gate(gate),
    .outbound_clock(clk_out),
    .inbound_clock(clk_in),
    .bit_one_local_in(loc[0]),
    .bit_two_local_in(loc[1]),
    .backplane_drive_enable(de),
    .monitor_enable_n(men),
    .bit_one_backplane_io_in(bit_in[0]),
    .bit_one_backplane_io_out(bit_out[0]),
    .bit_one_backplane_io_oe(bit_oe[0]),
    .bit_two_backplane_io_in(bit_in[1]),
    .bit_two_backplane_io_out(bit_out[1]),
    .bit_two_backplane_io_oe(bit_oe[1]),
    .bit_one_monitor_out(mon[0]),
    .bit_one_monitor_oe(mon_oe[0]),
    .bit_two_monitor_out(mon[1]),
    .bit_two_monitor_oe(mon_oe[1]),
    .capture_word(cap_word),
    .capture_valid(cap_valid),
    .capture_ready(cap_ready),
    .capture_room(cap_room)
  );

  backplane_model bp (
    .core_clk(core_clk),
    .drive_en(bp_en),
    .drive_val(bp_val),
    .octal_out(bp_out),
    .octal_oe(bp_oe),
    .bit_out(bit_out),
    .bit_oe(bit_oe),
    .bit_val(bit_val),
    .octal_wire(bp_in),
    .bit_wire(bit_in)
  );

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic print_verdict();
    $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  // inputs pass a synchroniser, so each change is given 8 cycles to land
  task automatic wt(input int n);
    repeat (n) @(negedge core_clk);
  endtask : wt

  // one direction-clock period, both phases longer than the filter needs
  task automatic pulse(input bit inb);
    @(negedge core_clk);
    if (inb) clk_in = 1'b1;
    else clk_out = 1'b1;
    wt(8);
    clk_in = 1'b0;
    clk_out = 1'b0;
    wt(8);
  endtask : pulse

  task automatic t_bits();
    for (int i = 0; i < 4; i++) begin
      @(negedge core_clk);
      de = {2{i[0]}};
      men = {2{i[1]}};
      loc = 2'b10;
      bit_val = 2'b01;
      // the echo from our own driver passes the synchroniser twice
      wt(12);
      chk(8'(bit_oe), 8'({2{i[0]}}));
      chk(8'(mon_oe), 8'({2{~i[1]}}));
      if (i[0]) chk(8'(bit_out), 8'h02);
      // i of 0 and 3 are the tied direction line of an outside controller
      if (!i[1]) chk(8'(mon), i[0] ? 8'h02 : 8'h01);
    end
  endtask : t_bits

  task automatic t_octal();
    gate = 1'b1;
    card_drv = 8'h5a;
    dir = 1'b1;
    wt(8);
    chk(bp_oe, 8'h00);
    chk(card_oe, 8'h00);
    oe_n = 1'b0;
    wt(8);
    chk(bp_oe, 8'hff);
    chk(bp_out, 8'h5a);
    card_drv = 8'ha5;
    wt(8);
    chk(bp_out, 8'ha5);
    dir = 1'b0;
    wt(8);
    chk(card_oe, 8'hff);
    chk(bp_oe, 8'h00);
    dir = 1'b1;
    card_drv = 8'h3c;
    wt(8);
  endtask : t_octal

  // gate falls while the clock is high: the level from before the fall stays
  task automatic t_latch();
    clk_out = 1'b1;
    wt(8);
    gate = 1'b0;
    wt(8);
    card_drv = 8'hc3;
    wt(8);
    chk(bp_out, 8'h3c);
    clk_out = 1'b0;
    wt(8);
    chk(bp_out, 8'h3c);
    pulse(1'b0);
    chk(bp_out, 8'hc3);
  endtask : t_latch

  task automatic t_inbound();
    dir = 1'b0;
    bp_en = 1'b1;
    bp_val = 8'h9e;
    wt(8);
    pulse(1'b1);
    chk(card_out, 8'h9e);
    bp_val = 8'h61;
    wt(8);
    chk(card_out, 8'h9e);
    gate = 1'b1;
    wt(8);
    chk(card_out, 8'h61);
    gate = 1'b0;
    bp_en = 1'b0;
    dir = 1'b1;
  endtask : t_inbound

  task automatic t_disabled();
    oe_n = 1'b1;
    card_drv = 8'h77;
    // card pins only show the new word once our card driver has let go
    wt(12);
    pulse(1'b0);
    chk(bp_oe, 8'h00);
    oe_n = 1'b0;
    wt(8);
    chk(bp_out, 8'h77);
  endtask : t_disabled

  // receiver stalls over three captures: two are kept in order, the third dropped
  task automatic t_buffer();
    cap_ready = 1'b0;
    for (int k = 0; k < 3; k++) begin
      card_drv = 8'h11 * 8'(k + 1);
      pulse(1'b0);
    end
    chk(8'(cap_room), 8'h00);
    chk(8'(cap_valid), 8'h01);
    chk(cap_word, 8'h11);
    for (int k = 0; k < 2; k++) begin
      chk(cap_word, 8'h11 * 8'(k + 1));
      cap_ready = 1'b1;
      @(negedge core_clk);
      cap_ready = 1'b0;
      wt(2);
    end
    chk(8'(cap_valid), 8'h00);
    chk(8'(cap_room), 8'h01);
  endtask : t_buffer

  initial begin
    {oe_n, dir, gate, clk_out, clk_in, bp_en, cap_ready} = 7'h41;
    {card_drv, bp_val, loc, de, bit_val} = '0;
    men = 2'b11;
    sys_rst = 1'b1;
    wt(10);
    chk(bp_oe | card_oe, 8'h00);
    chk(8'({bit_oe, mon_oe, cap_valid, cap_room}), 8'h01);
    sys_rst = 1'b0;
    wt(2);
    t_bits();
    t_octal();
    t_latch();
    t_inbound();
    t_disabled();
    t_buffer();
    print_verdict();
  end

  // the whole run needs about 290 cycles
  initial begin
    #200000;
    n_mismatch++;
    print_verdict();
  end
endmodule : bus_transceiver_tb
